// file: dv/dram_termination_mode_control_tb.sv
// bench joining the termination controller to the dram end
`timescale 1ns/10ps
module dram_termination_mode_control_tb
   import dtm_pkg::*;
();
   typedef struct {dtm_cmd_t c; logic [15:0] d; logic ew;} dtm_row_t; // command, op code, strength expected
   logic clk = 1'b0; // 20 MHz clock
   logic rst_n = 1'b0; // reset, low active
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic asyncResp;
   logic powerDown;
   logic entryPeriod;
   logic exitPeriod;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   // mrs2 early so the writes after it switch strength
   dtm_row_t rows[7] = '{'{CMD_MRS0, 16'h1000, 1'b0}, '{CMD_MRS2, 16'h0600, 1'b0}, '{CMD_NOP, 16'h0, 1'b0},
      '{CMD_REF, 16'h0, 1'b0}, '{CMD_RD, 16'h0, 1'b0}, '{CMD_WR4, 16'h0, 1'b1}, '{CMD_WR8, 16'h0, 1'b1}};
   dtm_link_if link();
   dtm_term_ctrl dtm_term_ctrl_inst (.clk(clk), .rst_n(rst_n), .link(link), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
   // long refresh so a refresh in progress outlasts the cke-low hold
   dtm_term_device #(.REFRESH_TIME(8)) dtm_term_device_inst (.clk(clk), .rst_n(rst_n), .link(link),
      .asyncResp(asyncResp),
      .powerDown(powerDown), .entryPeriod(entryPeriod), .exitPeriod(exitPeriod));
   dtm_term_asserts dtm_term_asserts_inst (.clk(clk), .rst_n(rst_n), .odt(link.odt), .cke(link.cke),
      .cmd(link.cmd), .cmdAddr(link.cmdAddr), .termOn(link.termOn), .termWrite(link.termWrite),
      .asyncResp(asyncResp));
   // clock
   always #25 clk = ~clk;
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         results();
      end
   end
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one write cycle; starts on an edge so strobes never change twice in a step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // one read cycle, data looked at in the single cycle it stands
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata & m, e);
   endtask
   // idle cycles, ending just after an edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // every link and status output except cmdAddr at its reset value
   task automatic rst_chk();
      chk({21'h0, link.cmd, link.odt, link.cke, link.termOn, link.termWrite, asyncResp, powerDown,
         entryPeriod, exitPeriod}, 32'h40);
      chk(regRdata, 32'h0);
   endtask
   // verdict
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      // flops take reset at the first edge, as rst_n starts low with no falling edge
      repeat (9) @(posedge clk);
      #1 rst_chk();
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 rst_chk();
      $display("test reset done");
      foreach (rows[i]) begin
         wr(REG_DATA, {16'h0, rows[i].d});
         wr(REG_CMD, {29'h0, rows[i].c});
         #1 chk(link.cmd, rows[i].c);
         if (rows[i].c inside {CMD_MRS0, CMD_MRS2}) begin
            chk(link.cmdAddr, rows[i].d);
         end
         cyc(4);
         chk(link.termWrite, rows[i].ew);
         cyc(8);
         chk(link.termWrite, 1'b0);
      end
      $display("test commands done");
      // sync latency, then a burst write that stretches the odt hold
      wr(REG_CTRL, 32'h1);
      cyc(3);
      chk(link.termOn, 1'b0);
      cyc(1);
      chk(link.termOn, 1'b1);
      wr(REG_CMD, {29'h0, CMD_WR8});
      wr(REG_CTRL, 32'h0);
      rd(REG_STATUS, 32'h2, 32'h2);
      cyc(12);
      rd(REG_STATUS, 32'h2, 32'h0);
      // chop write with odt high keeps it up three cycles past the write
      wr(REG_CTRL, 32'h1);
      wr(REG_CMD, {29'h0, CMD_WR4});
      wr(REG_CTRL, 32'h0);
      rd(REG_STATUS, 32'h2, 32'h2);
      rd(REG_STATUS, 32'h2, 32'h0);
      $display("test hold done");
      // dll-off forces the write strength field to zero
      wr(REG_CTRL, 32'h2);
      wr(REG_DATA, 32'h0600);
      wr(REG_CMD, {29'h0, CMD_MRS2});
      #1 chk(link.cmdAddr[10:9], 2'b00);
      wr(REG_CMD, {29'h0, CMD_WR8});
      cyc(5);
      chk(link.termWrite, 1'b0);
      wr(REG_CTRL, 32'h0);
      $display("test dll-off done");
      // frozen power-down entered with a refresh still running
      wr(REG_DATA, 32'h0);
      wr(REG_CMD, {29'h0, CMD_MRS0});
      wr(REG_CMD, {29'h0, CMD_REF});
      wr(REG_CTRL, 32'h4);
      cyc(2);
      chk(entryPeriod, 1'b1);
      cyc(4);
      chk({entryPeriod, asyncResp, powerDown}, 3'b111);
      wr(REG_CTRL, 32'h5);
      cyc(1);
      chk({link.termOn, entryPeriod}, 2'b10);
      wr(REG_CMD, {29'h0, CMD_WR8});
      #1 chk(link.cmd, CMD_NOP);
      rd(REG_STATUS, 32'h8, 32'h8);
      wr(REG_STATUS, 32'h8);
      rd(REG_STATUS, 32'h8, 32'h0);
      wr(REG_CTRL, 32'h4);
      cyc(1);
      chk(link.termOn, 1'b0);
      rd(4'h7, 32'hffffffff, 32'h0);
      wr(REG_CTRL, 32'h0);
      cyc(1);
      chk(exitPeriod, 1'b1);
      cyc(7);
      chk({exitPeriod, asyncResp}, 2'b00);
      $display("test frozen power-down done");
      // dll kept running in power-down: timing stays synchronous
      wr(REG_DATA, 32'h1000);
      wr(REG_CMD, {29'h0, CMD_MRS0});
      wr(REG_CTRL, 32'h4);
      cyc(4);
      chk({asyncResp, powerDown, entryPeriod}, 3'b010);
      wr(REG_CTRL, 32'h0);
      cyc(8);
      $display("test running power-down done");
      // reset in mid-run with termination requested during power-down
      wr(REG_CTRL, 32'h5);
      cyc(4);
      @(posedge clk);
      rst_n <= 1'b0;
      #1 rst_chk();
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 rst_chk();
      rd(REG_CTRL, 32'h7, 32'h0);
      $display("test mid-run reset done");
      results();
   end
endmodule

// file: dv/dtm_term_asserts.sv
// checker on the termination link between controller and dram ends
`timescale 1ns/10ps
module dtm_term_asserts
   import dtm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link signals
   input wire logic odt,
   input wire logic cke,
   input wire dtm_cmd_t cmd,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic termOn,
   input wire logic termWrite,
   // dram mode flag
   input wire logic asyncResp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic ckePrev; // cke on the previous edge
   logic frozen; // dll frozen in power-down
   logic dynOn; // write strength switching enabled
   wire honoured = cke && ckePrev; // a command counts only with cke high on both edges
   // mirror of the mode bits the dram has taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ckePrev <= 1'b1;
         frozen <= 1'b0;
         dynOn <= 1'b0;
      end else begin
         ckePrev <= cke;
         if (honoured && cmd == CMD_MRS0) begin
            frozen <= !cmdAddr[MR0_DLL_PD_BIT];
         end
         if (honoured && cmd == CMD_MRS2) begin
            dynOn <= |cmdAddr[MR2_WRTERM_MSB:MR2_WRTERM_LSB];
         end
      end
   end
   // guards keep cke steady so no mode change falls inside the window
   property p_sync_on;
      (!asyncResp && cke && $rose(odt) && !$past(odt, 2)) ##1 (cke && odt)[*4] |-> !$past(termOn, 1) && termOn;
   endproperty
   a_sync_on: assert property (p_sync_on) else $error("sync turn-on latency wrong");
   property p_sync_off;
      (!asyncResp && cke && $fell(odt)) ##1 (cke && !odt)[*4] |-> $past(termOn, 1) && !termOn;
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync turn-off latency wrong");
   property p_async_on;
      asyncResp && !cke && $rose(odt) |-> ##1 termOn;
   endproperty
   a_async_on: assert property (p_async_on) else $error("async turn-on late");
   property p_async_off;
      asyncResp && !cke && $fell(odt) |-> ##1 !termOn;
   endproperty
   a_async_off: assert property (p_async_off) else $error("async turn-off late");
   property p_frozen;
      frozen && $fell(cke) |-> ##[1:2] asyncResp;
   endproperty
   a_frozen: assert property (p_frozen) else $error("no async mode in frozen power-down");
   property p_sync_out;
      cke[*5] |-> !asyncResp;
   endproperty
   a_sync_out: assert property (p_sync_out) else $error("async mode outside power-down");
   property p_wr8;
      dynOn && !asyncResp && honoured && cmd == CMD_WR8 |-> !termWrite ##4 (termWrite[*6] ##1 !termWrite);
   endproperty
   a_wr8: assert property (p_wr8) else $error("write strength window wrong");
   property p_no_rdwr;
      !cke |-> !(cmd inside {CMD_RD, CMD_WR8, CMD_WR4});
   endproperty
   a_no_rdwr: assert property (p_no_rdwr) else $error("read or write in power-down");
   property p_hold;
      $rose(odt) |-> odt[*4];
   endproperty
   a_hold: assert property (p_hold) else $error("odt dropped too soon");
   property p_hold8;
      odt && cmd == CMD_WR8 |-> odt[*6];
   endproperty
   a_hold8: assert property (p_hold8) else $error("odt dropped after burst write");
   property p_hold4;
      odt && cmd == CMD_WR4 |-> odt[*4];
   endproperty
   a_hold4: assert property (p_hold4) else $error("odt dropped after chop write");
endmodule

// file: include/dtm_link_if.sv
// link between the memory controller and the dram termination logic
`timescale 1ns/10ps
interface dtm_link_if;
   import dtm_pkg::*;
   logic odt; // termination request input
   logic cke; // clock enable, low in power-down
   dtm_cmd_t cmd; // command of this cycle
   logic [ADDR_W-1:0] cmdAddr; // mode register op code
   logic termOn; // termination resistance on
   logic termWrite; // write strength selected
   modport dev(input odt, cke, cmd, cmdAddr, output termOn, termWrite);
   modport ctl(output odt, cke, cmd, cmdAddr, input termOn, termWrite);
endinterface

// file: include/dtm_pkg.sv
// shared constants and types for the termination control link
package dtm_pkg;
   // clock period of the system clock in ns
   localparam real CLK_NS = 50.0;
   // asynchronous termination delays in ns
   localparam real ASYNC_ON_MIN_NS = 2.0;
   localparam real ASYNC_ON_MAX_NS = 8.5;
   localparam real ASYNC_OFF_MIN_NS = 2.0;
   localparam real ASYNC_OFF_MAX_NS = 8.5;
   // least time rounds up, longest rounds down, never under one cycle
   localparam int ASYNC_MIN_RAW = int'($ceil(ASYNC_ON_MIN_NS / CLK_NS));
   localparam int ASYNC_MAX_RAW = int'($floor(ASYNC_ON_MAX_NS / CLK_NS));
   localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
   localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
   // default write latency parts in clock cycles
   localparam int DEF_CWL = 5;
   localparam int DEF_AL = 0;
   // minimum termination-input high times in cycles
   localparam int MIN_HIGH_SHORT = 4;
   localparam int MIN_HIGH_LONG = 6;
   // extra cycles before write termination returns to nominal
   localparam int WR_BACK_CHOP = 4;
   localparam int WR_BACK_BURST = 6;
   // minimum clock-enable-low hold in cycles
   localparam int DEF_CKE_LOW_CYC = 3;
   // refresh cycle time and dll-locked exit time in ns
   localparam real REFRESH_NS = 110.0;
   localparam real DLL_EXIT_NS = 24.0;
   localparam int REFRESH_CYC = int'($ceil(REFRESH_NS / CLK_NS));
   localparam int DLL_EXIT_CYC = int'($ceil(DLL_EXIT_NS / CLK_NS));
   // mode register field positions
   localparam int ADDR_W = 16;
   localparam int MR0_DLL_PD_BIT = 12;
   localparam int MR2_WRTERM_LSB = 9;
   localparam int MR2_WRTERM_MSB = 10;
   // controller register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   // control register fields
   localparam int CTRL_ODT_BIT = 0;
   localparam int CTRL_DLLOFF_BIT = 1;
   localparam int CTRL_PD_BIT = 2;
   // status register fields
   localparam int STAT_REFUSED_BIT = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // commands on the link
   typedef enum logic [2:0] {
      CMD_NOP, CMD_WR8, CMD_WR4, CMD_RD, CMD_REF, CMD_MRS0, CMD_MRS2
   } dtm_cmd_t;
endpackage

// file: verilog/dtm_term_ctrl.sv
// controller end: drives termination, clock enable and commands
`timescale 1ns/10ps
module dtm_term_ctrl
   import dtm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link to the dram
   dtm_link_if.ctl link,
   // software register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata
);
   localparam logic [2:0] HOLD_SHORT = 3'(MIN_HIGH_SHORT - 1);
   localparam logic [2:0] HOLD_LONG = 3'(MIN_HIGH_LONG - 1);
   localparam logic [2:0] HOLD_ONE = 3'h1;

   logic [2:0] ctrl; // odt request, dll off, power-down request
   logic [ADDR_W-1:0] mrsData; // op code for the next mode register set
   logic refused; // sticky: read or write refused in power-down
   logic odtOut; // termination input driven
   logic ckeOut; // clock enable driven
   dtm_cmd_t cmdOut; // command driven this cycle
   logic [ADDR_W-1:0] addrOut; // op code driven this cycle
   logic [2:0] holdCnt; // cycles the termination input must stay high

   // register decode
   wire wrCtrl = regWr & (regAddr == REG_CTRL);
   wire wrCmd = regWr & (regAddr == REG_CMD);
   wire wrData = regWr & (regAddr == REG_DATA);
   wire wrStat = regWr & (regAddr == REG_STATUS);
   wire [2:0] ctrlNow = wrCtrl ? regWdata[2:0] : ctrl;
   wire dtm_cmd_t op = dtm_cmd_t'(regWdata[2:0]);
   wire opRdWr = (op == CMD_RD) | (op == CMD_WR8) | (op == CMD_WR4);
   wire opWr = (op == CMD_WR8) | (op == CMD_WR4);
   // reads and writes are refused while clock enable is low
   wire refuse = wrCmd & opRdWr & ~ckeOut; // RL6
   wire issue = wrCmd & ~refuse;
   // termination stays up while requested or while a hold runs
   wire next_odt = ctrlNow[CTRL_ODT_BIT] | (holdCnt != 3'h0); // RL12
   wire odtRise = next_odt & ~odtOut;
   wire [2:0] holdDec = (holdCnt != 3'h0) ? holdCnt - HOLD_ONE : 3'h0;
   wire [2:0] wrHold = (op == CMD_WR8) ? HOLD_LONG : HOLD_SHORT; // RL13 RL14
   wire [2:0] loadA = odtRise ? HOLD_SHORT : 3'h0; // RL12
   wire [2:0] loadB = (issue & opWr & next_odt) ? wrHold : 3'h0; // RL13 RL14
   wire [2:0] loadMax = (loadA > loadB) ? loadA : loadB;
   wire [2:0] next_hold = (loadMax > holdDec) ? loadMax : holdDec;
   // dynamic termination forced off with the dll off
   wire [ADDR_W-1:0] mrs2Data = ctrl[CTRL_DLLOFF_BIT] ?
      {mrsData[ADDR_W-1:MR2_WRTERM_MSB+1], 2'h0, mrsData[MR2_WRTERM_LSB-1:0]} : mrsData; // RL17
   wire [ADDR_W-1:0] next_addr = (op == CMD_MRS2) ? mrs2Data : mrsData;
   wire [31:0] statusWord = {26'h0, link.termWrite, link.termOn, refused,
                             holdCnt != 3'h0, odtOut, ckeOut};
   wire [31:0] readMux = (regAddr == REG_CTRL) ? {29'h0, ctrl} :
                         (regAddr == REG_DATA) ? {16'h0, mrsData} :
                         (regAddr == REG_STATUS) ? statusWord : 32'h0;

   assign link.odt = odtOut;
   assign link.cke = ckeOut;
   assign link.cmd = cmdOut;
   assign link.cmdAddr = addrOut;

   // software registers; a refusal in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         mrsData <= '0;
         refused <= 1'b0;
      end else begin
         ctrl <= ctrlNow;
         if (wrData) begin
            mrsData <= regWdata[ADDR_W-1:0];
         end
         refused <= refuse | (refused & ~(wrStat & regWdata[STAT_REFUSED_BIT])); // RL6
      end
   end

   // link outputs; commands last one cycle then fall back to no-op
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         odtOut <= 1'b0;
         ckeOut <= 1'b1;
         cmdOut <= CMD_NOP;
         addrOut <= '0;
         holdCnt <= 3'h0;
      end else begin
         odtOut <= next_odt; // RL12 RL13 RL14
         holdCnt <= next_hold;
         ckeOut <= ~ctrlNow[CTRL_PD_BIT];
         cmdOut <= issue ? op : CMD_NOP; // RL6
         addrOut <= issue ? next_addr : addrOut;
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 32'h0;
      end else begin
         regRdata <= regRd ? readMux : 32'h0;
      end
   end
endmodule

// file: verilog/dtm_term_device.sv
// dram end: on-die termination timing, sync, async and transitions
// Operation
// RL1: dll frozen power-down selects asynchronous timing
// RL2: async path ignores additive latency
// RL3: async turn-on between 2 and 8.5 ns
// RL4: async turn-off between 2 and 8.5 ns
// RL5: termination input stays live in power-down
// RL6: no read or write during power-down
// RL7: entry period spans write latency minus one
// RL8: refresh in progress can stretch entry period
// RL9: turn-on in transition may be either timing
// RL10: turn-off in transition may be either timing
// RL11: exit period ends dll exit time later
// RL12: termination input held high four cycles
// RL13: burst write holds input high six cycles
// RL14: chop write holds input high four cycles
// RL15: sync on and off at latency minus two
// RL16: dynamic switch to write strength and back
// RL17: controller disables dynamic termination with dll off
// RL18: async inside power-down, sync outside
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module dtm_term_device
   import dtm_pkg::*;
#(
   parameter int CAS_WRITE_LATENCY = DEF_CWL,
   parameter int ADDITIVE_LATENCY = DEF_AL,
   parameter int CKE_LOW_MIN = DEF_CKE_LOW_CYC,
   parameter int REFRESH_TIME = REFRESH_CYC,
   parameter int DLL_EXIT_TIME = DLL_EXIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link to the controller
   dtm_link_if.dev link,
   // observation of internal state
   output logic asyncResp,
   output logic powerDown,
   output logic entryPeriod,
   output logic exitPeriod
);
   // write latency and the sync latency derived from it
   localparam int WRITE_LATENCY = CAS_WRITE_LATENCY + ADDITIVE_LATENCY;
   localparam int SYNC_LAT = WRITE_LATENCY - 2;
   // one flop per cycle of latency; the output flop is not counted as a stage
   localparam int PIPE_LEN = (SYNC_LAT > 1) ? SYNC_LAT : 1;
   localparam int CW = 8;
   localparam logic [CW-1:0] CNT_ONE = 8'h01;
   localparam logic [CW-1:0] SYNC_LAT_C = CW'(SYNC_LAT);
   localparam logic [CW-1:0] BACK_CHOP_C = CW'(SYNC_LAT + WR_BACK_CHOP);
   localparam logic [CW-1:0] BACK_BURST_C = CW'(SYNC_LAT + WR_BACK_BURST);
   localparam logic [CW-1:0] CKE_LOW_C = CW'(CKE_LOW_MIN);
   localparam logic [CW-1:0] REFRESH_C = CW'(REFRESH_TIME);
   localparam logic [CW-1:0] DLL_EXIT_C = CW'(DLL_EXIT_TIME);

   logic dllFrozen; // mode register zero selects frozen dll in power-down
   logic [1:0] wrTermField; // write termination field of mode register two
   logic ckePrev; // clock enable of the previous edge
   logic [PIPE_LEN-1:0] syncPipe; // delay line for synchronous response
   logic [CW-1:0] lowCnt; // cycles since clock enable fell
   logic [CW-1:0] refCnt; // refresh still in progress countdown
   logic [CW-1:0] exitCnt; // cycles since clock enable rose
   logic [CW-1:0] wrCnt; // cycles since the last write
   logic wrChop; // last write was a four-beat chop
   logic termActive; // termination state
   logic writeSel; // write strength selected

   // command decode, honoured only while the command receivers are live
   wire cmdLive = link.cke & ckePrev;
   wire isWr8 = cmdLive & (link.cmd == CMD_WR8);
   wire isWr4 = cmdLive & (link.cmd == CMD_WR4);
   wire isWrite = isWr8 | isWr4;
   wire isRef = cmdLive & (link.cmd == CMD_REF);
   wire isMrs0 = cmdLive & (link.cmd == CMD_MRS0);
   wire isMrs2 = cmdLive & (link.cmd == CMD_MRS2);
   wire ckeFall = ckePrev & ~link.cke;
   wire ckeRise = ~ckePrev & link.cke;
   wire dynEnable = wrTermField != 2'h0;

   // entry period ends once both the cke-low hold and any refresh are done
   wire entryDone = (lowCnt >= CKE_LOW_C) & (refCnt == '0); // RL7 RL8
   wire exitDone = exitCnt >= DLL_EXIT_C; // RL11
   // response selection: async in frozen-dll power-down and while leaving it
   wire next_async = dllFrozen & (~link.cke | exitPeriod & ~exitDone); // RL1 RL18
   // synchronous output of the delay line
   wire syncTerm = syncPipe[PIPE_LEN-1]; // RL15
   // write strength window after a write
   wire [CW-1:0] backCnt = wrChop ? BACK_CHOP_C : BACK_BURST_C;
   wire next_writeSel = dynEnable & ~next_async & (wrCnt >= SYNC_LAT_C)
                        & (wrCnt < backCnt); // RL16

   assign link.termOn = termActive;
   assign link.termWrite = writeSel;

   // mode register capture; dll frozen when the bit reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dllFrozen <= 1'b0;
         wrTermField <= 2'h0;
      end else begin
         if (isMrs0) begin
            dllFrozen <= ~link.cmdAddr[MR0_DLL_PD_BIT]; // RL1
         end
         if (isMrs2) begin
            wrTermField <= link.cmdAddr[MR2_WRTERM_MSB:MR2_WRTERM_LSB];
         end
      end
   end

   // clock enable history and power-down state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ckePrev <= 1'b1;
         powerDown <= 1'b0;
      end else begin
         ckePrev <= link.cke;
         powerDown <= ~link.cke;
      end
   end

   // the termination receiver samples every cycle, power-down or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncPipe <= '0;
      end else begin
         syncPipe <= (syncPipe << 1) | PIPE_LEN'(link.odt); // RL5
      end
   end

   // refresh in progress countdown
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refCnt <= '0;
      end else if (isRef) begin
         refCnt <= REFRESH_C - CNT_ONE; // RL8
      end else if (refCnt != '0) begin
         refCnt <= refCnt - CNT_ONE;
      end
   end

   // entry period: the early part before cke fell is covered by the
   // sync delay line still draining, so only the tail is tracked here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt <= '0;
         entryPeriod <= 1'b0;
      end else if (ckeFall) begin
         lowCnt <= CNT_ONE;
         entryPeriod <= dllFrozen; // RL7
      end else begin
         if (lowCnt != '1) begin
            lowCnt <= lowCnt + CNT_ONE;
         end
         // both endpoints belong to the period, so clear one edge later
         if (entryDone | link.cke) begin
            entryPeriod <= 1'b0; // RL7 RL8
         end
      end
   end

   // exit period counted from the first edge with cke high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exitCnt <= '0;
         exitPeriod <= 1'b0;
      end else if (ckeRise) begin
         exitCnt <= CNT_ONE;
         exitPeriod <= dllFrozen; // RL11
      end else if (exitPeriod) begin
         exitCnt <= exitCnt + CNT_ONE;
         if (exitDone | ~link.cke) begin
            exitPeriod <= 1'b0; // RL11
         end
      end
   end

   // write tracking for dynamic strength switching
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrCnt <= BACK_BURST_C;
         wrChop <= 1'b0;
      end else if (isWrite) begin
         wrCnt <= CNT_ONE;
         wrChop <= isWr4; // RL16
      end else if (wrCnt < backCnt) begin
         wrCnt <= wrCnt + CNT_ONE;
      end
   end

   // termination output: async path is one cycle and bypasses additive
   // latency; within transition periods either answer is legal, so the
   // switch simply follows the response selection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         termActive <= 1'b0;
         writeSel <= 1'b0;
         asyncResp <= 1'b0;
      end else begin
         asyncResp <= next_async;
         if (next_async) begin
            termActive <= link.odt; // RL2 RL3 RL4 RL9 RL10
         end else begin
            termActive <= syncTerm; // RL15 RL9 RL10 RL18
         end
         writeSel <= next_writeSel; // RL16
      end
   end
endmodule
